// ### hdl/vtr_timing.sv
`timescale 1ns/100ps
`default_nettype none
module vtr_timing #(
	parameter int DOT_DIV = vtr_pkg::DOTS_PER_CHAR  // clocks per character position
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// options and processor control pins
	input  wire logic              rate_50hz,      // frame-rate option
	input  wire logic              row_ptr_reset,  // processor pointer reset pulse
	input  wire logic              scroll,         // processor scroll pulse
	// processor memory access pins
	input  wire logic              load_select,    // high: load address drives memory
	input  wire vtr_pkg::vtr_addr_t load_addr,
	input  wire logic [7:0]        bus_wr_data,    // code on 6:0, cursor on 7
	input  wire logic              intensity_in,   // port 0 bit 1
	input  wire logic              mem_write,
	input  wire logic              mem_read,
	// outputs
	output logic [7:0]             bus_rd_data,
	output logic                   bus_oe_n,       // low while buffer drives bus
	output logic                   intensity_rd,
	output logic                   display_window_n,
	output logic                   vsync_n,
	output logic                   hsync,
	output logic [4:0]             top_row_pointer,
	output vtr_pkg::vtr_word_t     disp_word       // word fetched for display
);
	import vtr_pkg::*;

	// two-flop synchronisers for processor pins
	// seven control bits, eight data bits and eight upper address bits
	localparam int NS = 23;
	logic [NS-1:0] sync1;         // first stage, read only by sync2
	logic [NS-1:0] sync2;
	always_ff @(posedge clk_sys) begin
		sync1 <= {rate_50hz, row_ptr_reset, scroll, load_select, mem_write, mem_read,
			intensity_in, bus_wr_data, load_addr[11:7], load_addr[6:4]};
		sync2 <= sync1;
	end
	// load column bits 3:0 pass the same two flops, kept in a separate vector below
	logic [3:0] lcol_lo1;
	logic [3:0] lcol_lo2;
	always_ff @(posedge clk_sys) begin
		lcol_lo1 <= load_addr[3:0];
		lcol_lo2 <= lcol_lo1;
	end
	logic      s_50, s_rst, s_scr, s_sel, s_wr, s_rd, s_int;
	logic [7:0] s_data;
	vtr_addr_t  s_laddr;
	assign {s_50, s_rst, s_scr, s_sel, s_wr, s_rd, s_int, s_data} = sync2[NS-1:8];
	assign s_laddr = {sync2[7:0], lcol_lo2};

	// state of the timing chain
	logic [2:0] dot_cnt;          // divides clock to character rate
	logic [6:0] col;
	logic [3:0] char_line;
	logic [8:0] scan_line_counter;
	logic       display_window_flag;
	logic       vertical_sync_flag;
	logic       scr_d;            // previous scroll level for edge detect
	logic       rst_d;
	logic       wr_d;
	logic [2:0] next_dot_cnt;
	logic [6:0] next_col;
	logic [3:0] next_char_line;
	logic [8:0] next_scan;
	logic       next_win, next_vs, next_hs;
	logic [4:0] next_ptr;
	logic       char_stb, line_stb, row_end, scr_pulse, rst_pulse;
	logic [8:0] vs_set;

	// next state of counters and flags: dot_cnt every clock, the rest on strobes or processor pulses
	always_comb begin
		char_stb  = (dot_cnt == 3'(DOT_DIV - 1));
		line_stb  = char_stb && (col == COL_LAST);
		row_end   = char_stb && (col == COL_ROW_DONE)
			&& (char_line == CHAR_LINE_LAST);
		scr_pulse = s_scr && !scr_d;
		rst_pulse = s_rst && !rst_d;
		vs_set    = s_50 ? VSYNC_SET_50 : VSYNC_SET_60;
		next_dot_cnt   = char_stb ? 3'h0 : dot_cnt + 3'h1;
		next_col       = !char_stb ? col : (col == COL_LAST) ? 7'h00 : col + 7'h01;
		next_hs        = hsync;
		if (char_stb && col == HSYNC_START - 7'h01) next_hs = 1'b1;
		if (char_stb && col == HSYNC_END - 7'h01)   next_hs = 1'b0;
		next_char_line = char_line;
		if (row_end)
			next_char_line = 4'h0;
		else if (char_stb && col == COL_ROW_DONE && display_window_flag)
			next_char_line = char_line + 4'h1;
		next_scan = scan_line_counter;
		next_win  = display_window_flag;
		next_vs   = vertical_sync_flag;
		if (line_stb) begin
			// restart at the sync set point, else count lines
			next_scan = (scan_line_counter + 9'h001 == vs_set) ? 9'h000
				: scan_line_counter + 9'h001;
			if (next_scan == VWIN_SET) next_win = 1'b1;
			if (next_scan == VWIN_CLR) next_win = 1'b0;
			if (next_scan == 9'h000)   next_vs  = 1'b1;
			if (next_scan == VSYNC_CLR) next_vs = 1'b0;
		end
		// pointer: reset first, then each advance source
		next_ptr = top_row_pointer;
		if (rst_pulse)
			next_ptr = 5'h00;
		else if ((row_end && display_window_flag) || scr_pulse)
			next_ptr = (top_row_pointer == ROW_LAST) ? 5'h00 : top_row_pointer + 5'h01;
	end

	// register the timing chain
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dot_cnt             <= 3'h0;
			col                 <= 7'h00;
			char_line           <= 4'h0;
			scan_line_counter   <= 9'h000;
			display_window_flag <= 1'b0;
			vertical_sync_flag  <= 1'b1;
			hsync               <= 1'b0;
			top_row_pointer     <= 5'h00;
			scr_d               <= 1'b0;
			rst_d               <= 1'b0;
		end else begin
			dot_cnt             <= next_dot_cnt;
			col                 <= next_col;
			char_line           <= next_char_line;
			scan_line_counter   <= next_scan;
			display_window_flag <= next_win;
			vertical_sync_flag  <= next_vs;
			hsync               <= next_hs;
			top_row_pointer     <= next_ptr;
			scr_d               <= s_scr;
			rst_d               <= s_rst;
		end
	end

	// folded address and bank select
	// result is the bank select on top of a ten-bit word index
	// limitation: the lower bank ignores row bit 3, so rows eight apart share cells
	function automatic logic [MEM_AW-1:0] fold(input vtr_addr_t a);
		logic hi;
		hi = a.row[4] | a.col[6];
		fold = {hi, (hi ? a.row[3] : a.col[6]), a.row[2:0],
			a.col[5] | (a.col[6] & a.row[3]),
			a.col[4] | (a.col[6] & a.row[4]), a.col[3:0]};
	endfunction : fold

	// display address: row taken from pointer, column gated past 80
	vtr_addr_t disp_addr;
	vtr_addr_t sel_addr;
	logic      col_ovf_n;
	logic [MEM_AW-1:0] mem_addr;  // bank select and word index
	always_comb begin
		col_ovf_n = (col < COL_DISP_END);
		// the pointer steps once per character row, so it is the display row
		disp_addr.row = top_row_pointer;
		disp_addr.col = {col[6] & col_ovf_n, col[5] & col_ovf_n, col[4:0]};
		sel_addr  = s_sel ? s_laddr : disp_addr;
		mem_addr  = fold(sel_addr);
	end

	// two banks of the refresh memory, 1024 words each
	vtr_word_t lower_bank [MEM_WORDS/2];
	vtr_word_t upper_bank [MEM_WORDS/2];
	vtr_word_t rd_word;
	always_ff @(posedge clk_sys) begin
		wr_d <= s_wr;
		if (s_sel && s_wr && !wr_d) begin
			if (mem_addr[MEM_AW-1])
				upper_bank[mem_addr[9:0]] <= {s_int, s_data};
			else
				lower_bank[mem_addr[9:0]] <= {s_int, s_data};
		end
		// registered read: display and load side both see the word one edge later
		rd_word <= mem_addr[MEM_AW-1] ? upper_bank[mem_addr[9:0]] : lower_bank[mem_addr[9:0]];
	end

	// bus buffer and display outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bus_oe_n         <= 1'b1;
			bus_rd_data      <= 8'h00;
			intensity_rd     <= 1'b0;
			display_window_n <= 1'b1;
			vsync_n          <= 1'b1;
			disp_word        <= '0;
		end else begin
			bus_oe_n         <= !(s_sel && s_rd);
			bus_rd_data      <= {rd_word.cursor, rd_word.code};
			intensity_rd     <= rd_word.intensity;
			display_window_n <= !display_window_flag;
			vsync_n          <= !vertical_sync_flag;
			disp_word        <= s_sel ? '0 : rd_word;
		end
	end
endmodule : vtr_timing
`default_nettype wire

// ### hdl/vtr_pkg.sv
package vtr_pkg;
	// horizontal timing: clocks per character, then character positions
	localparam int          DOTS_PER_CHAR   = 6;
	localparam logic [6:0]  COL_LAST        = 7'h68;  // 104, modulo 105
	localparam logic [6:0]  COL_DISP_END    = 7'h50;  // 80 display columns
	localparam logic [6:0]  COL_ROW_DONE    = 7'h51;  // 81: last char of row done
	localparam logic [6:0]  HSYNC_START     = 7'h58;  // 88
	localparam logic [6:0]  HSYNC_END       = 7'h14;  // 20
	// vertical timing, in scan lines
	localparam logic [8:0]  VWIN_SET        = 9'h010; // 16
	localparam logic [8:0]  VWIN_CLR        = 9'h100; // 256
	localparam logic [8:0]  VSYNC_SET_60    = 9'h104; // 260
	localparam logic [8:0]  VSYNC_SET_50    = 9'h138; // 312
	localparam logic [8:0]  VSYNC_CLR       = 9'h005; // 5
	// character geometry
	localparam logic [3:0]  CHAR_LINE_LAST  = 4'h9;   // modulo ten
	localparam logic [4:0]  ROW_LAST        = 5'h17;  // modulo 24
	// memory
	localparam int          MEM_WORDS       = 2048;
	localparam int          MEM_AW          = 11;
	localparam int          WORD_W          = 9;

	// one stored character word
	typedef struct packed {
		logic       intensity;
		logic       cursor;
		logic [6:0] code;
	} vtr_word_t;

	// a 12-bit logical address
	typedef struct packed {
		logic [4:0] row;
		logic [6:0] col;
	} vtr_addr_t;
endpackage : vtr_pkg

// ### tb/vtr_timing_props.sv
`timescale 1ns/100ps
`default_nettype none
module vtr_timing_props #(
	parameter int DOT_DIV = 6 // clocks per character
) (
	// watched pins
	input wire logic               clk_sys,
	input wire logic               rst_n,
	input wire logic               mem_read,
	input wire logic               load_select,
	input wire logic               bus_oe_n,
	input wire logic               display_window_n,
	input wire logic               vsync_n,
	input wire logic               hsync,
	input wire logic [4:0]         top_row_pointer,
	input wire vtr_pkg::vtr_word_t disp_word
);
	import vtr_pkg::*;
	localparam int LINE  = 105 * DOT_DIV;    // clocks per line
	localparam int HS_LO = 68 * DOT_DIV - 1; // low span, col 20 to 87
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// held past the input synchronisers, until the data is taken
	sequence read_held;
		(mem_read && load_select) [*5];
	endsequence
	sequence hs_gap;
		##[HS_LO:HS_LO] !hsync ##1 hsync;
	endsequence
	hs_gap_a: assert property ($fell(hsync) |-> hs_gap)
		else $error("hsync gap");
	line_len_a: assert property ($fell(hsync) |-> ##[LINE:LINE] $fell(hsync))
		else $error("line length");
	oe_on_a: assert property (read_held |-> !bus_oe_n)
		else $error("buffer shut");
	oe_off_a: assert property ((!mem_read) [*5] |-> bus_oe_n)
		else $error("buffer open");
	load_blank_a: assert property (load_select [*5] |-> disp_word == 9'h000)
		else $error("fetch in load");
	sync_win_a: assert property (!vsync_n |-> display_window_n)
		else $error("window in sync");
	ptr_range_a: assert property (top_row_pointer <= 5'h17)
		else $error("pointer range");
	ptr_step_a: assert property ($changed(top_row_pointer) |->
		top_row_pointer == 5'h00 || top_row_pointer == $past(top_row_pointer) + 5'h01)
		else $error("pointer jump");
endmodule : vtr_timing_props
bind vtr_timing vtr_timing_props #(.DOT_DIV(DOT_DIV)) u_props (.clk_sys, .rst_n, .mem_read,
	.load_select, .bus_oe_n, .display_window_n, .vsync_n, .hsync, .top_row_pointer, .disp_word);
`default_nettype wire

// ### tb/vtr_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module vtr_cpu_model (
	// clock and read answer
	input wire logic           clk_sys,
	input wire logic           bus_oe_n,
	input wire logic [7:0]     bus_rd_data,
	input wire logic           intensity_rd,
	// processor pins
	output logic               row_ptr_reset,
	output logic               scroll,
	output logic               load_select,
	output vtr_pkg::vtr_addr_t load_addr,
	output logic [7:0]         bus_wr_data,
	output logic               intensity_in,
	output logic               mem_write,
	output logic               mem_read
);
	import vtr_pkg::*;
	// idle, display owns the memory
	initial begin
		{row_ptr_reset, scroll, load_select, intensity_in, mem_write, mem_read} <= 6'h00;
		{load_addr, bus_wr_data} <= 20'h00000;
	end
	// called only outside row-end increments, spaced for synchronisers
	task automatic ctl(input logic clr);
		@(posedge clk_sys);
		if (clr) row_ptr_reset <= 1'b1;
		else scroll <= 1'b1;
		repeat (2) @(posedge clk_sys);
		{row_ptr_reset, scroll} <= 2'h0;
		repeat (4) @(posedge clk_sys);
	endtask : ctl
	// sel low gives a stray write that must be ignored
	task automatic wr(input vtr_addr_t a, input vtr_word_t w, input logic sel);
		@(posedge clk_sys);
		{load_select, load_addr} <= {sel, a};
		{bus_wr_data, intensity_in} <= {w.cursor, w.code, w.intensity};
		@(posedge clk_sys);
		mem_write <= 1'b1;
		repeat (4) @(posedge clk_sys);
		mem_write <= 1'b0;
		repeat (4) @(posedge clk_sys);
		load_select <= 1'b0;
		bus_wr_data <= ~bus_wr_data; // released bus drifts
	endtask : wr
	// hold until the buffer opens, take data one edge later
	task automatic rd(input vtr_addr_t a, output vtr_word_t w);
		int n;
		@(posedge clk_sys);
		{load_select, load_addr, mem_read} <= {1'b1, a, 1'b1};
		for (n = 0; n < 20 && bus_oe_n !== 1'b0; n++) @(posedge clk_sys);
		@(posedge clk_sys);
		w = {intensity_rd, bus_rd_data};
		{load_select, mem_read} <= 2'h0;
		// let the buffer shut, or the next read would see the old enable
		repeat (4) @(posedge clk_sys);
	endtask : rd
endmodule : vtr_cpu_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import vtr_pkg::*;
	localparam int LN = 105; // clocks per line, one clock per character
	logic       clk_sys = 1'b0, rst_n = 1'b0, rate_50hz = 1'b0;
	logic       row_ptr_reset, scroll, load_select, intensity_in, mem_write, mem_read;
	logic       bus_oe_n, intensity_rd, display_window_n, vsync_n, hsync;
	logic [7:0] bus_wr_data, bus_rd_data;
	logic [4:0] top_row_pointer;
	vtr_addr_t  load_addr;
	vtr_word_t  disp_word, got;
	int         cyc = 0, t_fall = 0, n_errors = 0, tests_run = 0;
	always #50 clk_sys = ~clk_sys;
	vtr_timing #(.DOT_DIV(1)) DUT (.clk_sys, .rst_n, .rate_50hz, .row_ptr_reset, .scroll,
		.load_select, .load_addr, .bus_wr_data, .intensity_in, .mem_write, .mem_read,
		.bus_rd_data, .bus_oe_n, .intensity_rd, .display_window_n, .vsync_n, .hsync,
		.top_row_pointer, .disp_word);
	vtr_cpu_model cpu (.clk_sys, .bus_oe_n, .bus_rd_data, .intensity_rd, .row_ptr_reset,
		.scroll, .load_select, .load_addr, .bus_wr_data, .intensity_in, .mem_write, .mem_read);
	task automatic close_out;
		$display("compares %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: %h expected %h", $time, g, e);
		end
	endtask : chk
	// hang guard: nearly three frames, the wait for the first sync and both checked frames, fit below it
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			n_errors++;
			close_out();
		end
	end
	// runs in the top margin, so no row-end increments interfere
	task automatic ptr_test;
		repeat (2) cpu.ctl(1'b0);
		chk(top_row_pointer, 5'h02);
		cpu.ctl(1'b1);
		chk(top_row_pointer, 5'h00);
		repeat (23) cpu.ctl(1'b0);
		chk(top_row_pointer, 5'h17);
		cpu.ctl(1'b0);
		chk(top_row_pointer, 5'h00);
	endtask : ptr_test
	// row 16 col 0 shares the lower word address, so banks must differ
	task automatic mem_test;
		vtr_addr_t a[3] = '{12'h000, 12'h800, 12'hBCF};
		vtr_word_t w[3] = '{9'h141, 9'h0AA, 9'h17F};
		foreach (a[i]) cpu.wr(a[i], w[i], 1'b1);
		cpu.wr(a[0], 9'h000, 1'b0);
		foreach (a[i]) begin
			cpu.rd(a[i], got);
			chk(got, w[i]);
		end
	endtask : mem_test
	// display fetch follows the column; past 80 the overflow gate folds it back
	task automatic disp_test;
		cpu.wr(12'h010, 9'h0C3, 1'b1);
		@(posedge hsync);
		repeat (19) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(disp_word, 9'h141);
		repeat (80) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(disp_word, 9'h0C3);
	endtask : disp_test
	// vertical decode points, counted from the sync fall
	task automatic frame_check(input logic r, input int lines, input logic first);
		int t0;
		logic [4:0] p0;
		@(posedge clk_sys);
		rate_50hz <= r;
		// times are read half a clock after each edge, clear of the counter update
		if (first) begin
			@(negedge vsync_n);
			@(negedge clk_sys);
			t_fall = cyc;
		end
		t0 = t_fall;
		@(posedge vsync_n);
		@(negedge clk_sys);
		chk(cyc - t0, 5 * LN);
		@(negedge display_window_n);
		@(negedge clk_sys);
		chk(cyc - t0, 16 * LN);
		p0 = top_row_pointer;
		repeat (10 * LN) @(posedge clk_sys);
		chk(top_row_pointer, (p0 == 5'h17) ? 5'h00 : p0 + 5'h01);
		@(posedge display_window_n);
		@(negedge clk_sys);
		chk(cyc - t0, 256 * LN);
		@(negedge vsync_n);
		@(negedge clk_sys);
		chk(cyc - t0, lines * LN);
		chk(top_row_pointer, p0);
		t_fall = cyc;
	endtask : frame_check
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		ptr_test();
		mem_test();
		disp_test();
		frame_check(1'b0, 260, 1'b1);
		frame_check(1'b1, 312, 1'b0);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
